// *** slbtx_pkg.sv ***
// shared constants and types for the segmented local bus transmit path
package slbtx_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int SEG_N  = 4;
  localparam int SEG_W  = 128;
  localparam int BUS_W  = SEG_N * SEG_W;
  localparam int MTY_W  = 4;
  localparam int CHAN_W = 8;
  localparam int CNT_W  = 12;
  localparam int WRD_W  = 6;
  localparam int FILL_W = 11;
  localparam int WORD_SHIFT = 3;

  typedef logic [CNT_W-1:0] slbtx_cnt_type;

  localparam slbtx_cnt_type SEG_BYTES  = 12'h010;
  localparam slbtx_cnt_type BUS_BYTES  = 12'h040;
  localparam slbtx_cnt_type WORD_ROUND = 12'h007;
  localparam slbtx_cnt_type SHORT_MIN  = 12'h040;
  localparam slbtx_cnt_type SHORT_MAX  = 12'h100;
  localparam slbtx_cnt_type SHORT_GRAN = 12'h01f;
  localparam slbtx_cnt_type BUS_GRAN   = 12'h03f;

  // ----------------------------------------------------------------
  // controller register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_LEN    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_MAX    = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_MIN    = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_SHORT  = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_CHAN   = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_NUM    = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_SENT   = 6'h20;

  localparam int CTRL_GO  = 0;
  localparam int CTRL_CLR = 1;
  localparam int ST_BUSY  = 0;
  localparam int ST_OVF   = 1;
  localparam int ST_BERR  = 2;
  localparam int ST_CFG   = 3;

  localparam slbtx_cnt_type LEN_RST   = 12'h108;
  localparam slbtx_cnt_type MAX_RST   = 12'h100;
  localparam slbtx_cnt_type MIN_RST   = 12'h040;
  localparam slbtx_cnt_type SHORT_RST = 12'h040;
  localparam logic [15:0]   NUM_RST   = 16'h0001;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_HALT = 2'b10
  } slbtx_state_type;

endpackage

// *** slbtx_if.sv ***
// segmented transmit bus between packet scheduler and burst framer
`timescale 1ns/10ps
interface slbtx_if;
  import slbtx_pkg::*;

  logic [SEG_N-1:0]        ena;
  logic [SEG_N-1:0]        sop;
  logic [SEG_N-1:0]        eop;
  logic [SEG_N-1:0]        force_burst;
  logic [SEG_N*MTY_W-1:0]  mty;
  logic [SEG_N*CHAN_W-1:0] chan;
  logic [BUS_W-1:0]        data;
  slbtx_cnt_type           burst_short;
  slbtx_cnt_type           burst_max;
  logic                    rdy;
  logic                    ovf;
  logic                    burst_err;

  modport dev (
    input  ena, sop, eop, force_burst, mty, chan, data,
    input  burst_short, burst_max,
    output rdy, ovf, burst_err
  );

  modport sched (
    output ena, sop, eop, force_burst, mty, chan, data,
    output burst_short, burst_max,
    input  rdy, ovf, burst_err
  );
endinterface

// *** slbtx_seg.sv ***
// per-segment burst bookkeeping of the framer
`timescale 1ns/10ps
module slbtx_seg (
  input  wire logic                    ena,
  input  wire logic                    sop,
  input  wire logic                    eop,
  input  wire logic                    force_bcw,
  input  wire logic [slbtx_pkg::MTY_W-1:0]  mty,
  input  wire logic [slbtx_pkg::CHAN_W-1:0] chan,
  input  wire logic [slbtx_pkg::CHAN_W-1:0] chan_prev,
  input  wire slbtx_pkg::slbtx_cnt_type     cnt_in,
  input  wire slbtx_pkg::slbtx_cnt_type     max_bytes,
  input  wire slbtx_pkg::slbtx_cnt_type     short_bytes,
  output logic                         bcw,
  output slbtx_pkg::slbtx_cnt_type     cnt_out,
  output logic [slbtx_pkg::WRD_W-1:0]  data_words,
  output logic [slbtx_pkg::WRD_W-1:0]  idle_words
);
  import slbtx_pkg::*;

  slbtx_cnt_type base;
  slbtx_cnt_type nbytes;
  slbtx_cnt_type used;
  slbtx_cnt_type pad;

  // a start, a forced word, a channel change or a full burst opens a burst
  // a start counts here even with a packet still open (interleaved)
  always_comb begin
    bcw = ena & (sop | force_bcw | (chan != chan_prev) |
                 (cnt_in >= max_bytes));
    base   = bcw ? '0 : cnt_in;
    nbytes = eop ? SEG_BYTES - slbtx_cnt_type'(mty) : SEG_BYTES;
    used   = base + nbytes;
    // short burst at packet end is padded with idle words
    pad = (ena && eop && used < short_bytes) ? short_bytes - used : '0;
    cnt_out = !ena ? cnt_in : (eop ? '0 : used);
    data_words = ena ? WRD_W'((nbytes + WORD_ROUND) >> WORD_SHIFT) : '0;
    idle_words = WRD_W'((pad + WORD_ROUND) >> WORD_SHIFT);
  end

endmodule

// *** slbtx_dev.sv ***
// burst framer end: counts burst words, back-pressure and overflow
`timescale 1ns/10ps
module slbtx_dev #(
  parameter int FILL_DEPTH  = 512,
  parameter int RDY_LEVEL   = 384,
  parameter int DRAIN_WORDS = 6
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  slbtx_if.dev                               lb,
  output logic [slbtx_pkg::SEG_N-1:0]        bcw_seg,
  output logic [slbtx_pkg::FILL_W-1:0]       ctl_words,
  output logic [slbtx_pkg::FILL_W-1:0]       idle_words,
  output logic [slbtx_pkg::FILL_W-1:0]       fill_level
);
  import slbtx_pkg::*;

  // ----------------------------------------------------------------
  // segment chain
  // ----------------------------------------------------------------
  slbtx_cnt_type         cnt_c  [SEG_N+1];
  logic [CHAN_W-1:0]     chan_c [SEG_N+1];
  logic [SEG_N-1:0]      bcw_c;
  logic [WRD_W-1:0]      dw_c   [SEG_N];
  logic [WRD_W-1:0]      iw_c   [SEG_N];
  slbtx_cnt_type         cnt_q;
  logic [CHAN_W-1:0]     chan_q;
  logic [FILL_W-1:0]     fill_q;
  logic [FILL_W-1:0]     fill_d;
  logic [FILL_W-1:0]     add_c;
  logic [FILL_W-1:0]     ctl_c;
  logic [FILL_W-1:0]     idl_c;
  logic                  rdy_q;
  logic                  ovf_q;
  logic                  berr_q;

  assign cnt_c[0]  = cnt_q;
  assign chan_c[0] = chan_q;

  // each 128-bit segment judged on its own; no start count is assumed,
  // so a cycle with several starts and ends is still counted
  for (genvar i = 0; i < SEG_N; i++) begin : g_seg
    slbtx_seg u_seg (
      .ena         (lb.ena[i]),
      .sop         (lb.sop[i]),
      .eop         (lb.eop[i]),
      .force_bcw   (lb.force_burst[i]),
      .mty         (lb.mty[i*MTY_W +: MTY_W]),
      .chan        (lb.chan[i*CHAN_W +: CHAN_W]),
      .chan_prev   (chan_c[i]),
      .cnt_in      (cnt_c[i]),
      .max_bytes   (lb.burst_max),
      .short_bytes (lb.burst_short),
      .bcw         (bcw_c[i]),
      .cnt_out     (cnt_c[i+1]),
      .data_words  (dw_c[i]),
      .idle_words  (iw_c[i])
    );
    assign chan_c[i+1] = lb.ena[i] ? lb.chan[i*CHAN_W +: CHAN_W]
                                   : chan_c[i];
  end

  // ----------------------------------------------------------------
  // word accounting
  // ----------------------------------------------------------------
  // sum of data, control and idle words the cycle adds to the lanes
  always_comb begin
    ctl_c = '0;
    idl_c = '0;
    add_c = '0;
    for (int i = 0; i < SEG_N; i++) begin
      ctl_c = ctl_c + FILL_W'(bcw_c[i]);
      idl_c = idl_c + FILL_W'(iw_c[i]);
      add_c = add_c + FILL_W'(dw_c[i]);
    end
    add_c = add_c + ctl_c + idl_c;
  end

  // drain is a fixed lane rate; clamps at empty so the level never wraps
  always_comb begin
    if (fill_q + add_c > FILL_W'(DRAIN_WORDS))
      fill_d = fill_q + add_c - FILL_W'(DRAIN_WORDS);
    else
      fill_d = '0;
  end

  // burst state carried between cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= '0;
      chan_q <= '0;
    end else begin
      cnt_q  <= cnt_c[SEG_N];
      chan_q <= chan_c[SEG_N];
    end
  end

  // lane fill level; frozen after overflow, data then is discarded
  always_ff @(posedge aclk) begin
    if (!aresetn)
      fill_q <= '0;
    else if (!ovf_q)
      fill_q <= fill_d;
  end

  // ----------------------------------------------------------------
  // flow control and error status
  // ----------------------------------------------------------------
  // overflow is sticky: only a reset of the path clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      if (fill_d > FILL_W'(FILL_DEPTH))
        ovf_q <= 1'b1;
      rdy_q <= !ovf_q && (fill_d < FILL_W'(RDY_LEVEL));
    end
  end

  // two burst words in one cycle flag the error for that cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)
      berr_q <= 1'b0;
    else
      berr_q <= (ctl_c > FILL_W'(1));
  end

  // per-cycle framing outputs for observation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcw_seg    <= '0;
      ctl_words  <= '0;
      idle_words <= '0;
      fill_level <= '0;
    end else begin
      bcw_seg    <= bcw_c;
      ctl_words  <= ctl_c;
      idle_words <= idl_c;
      fill_level <= fill_d;
    end
  end

  assign lb.rdy       = rdy_q;
  assign lb.ovf       = ovf_q;
  assign lb.burst_err = berr_q;

endmodule

// *** slbtx_sched.sv ***
// packet scheduler end: axi4-lite controlled, drives the segmented bus
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module slbtx_sched (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [slbtx_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [slbtx_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  slbtx_if.sched                             lb
);
  import slbtx_pkg::*;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0]  waddr_q;
  logic [31:0]        wdat_q;
  logic [3:0]         wstb_q;
  logic               aw_held_q;
  logic               w_held_q;
  logic               wr_fire;
  logic               wr_hit;

  assign wr_fire = aw_held_q && w_held_q && !bvalid;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_LEN) || (a == OFS_MAX) ||
             (a == OFS_MIN) || (a == OFS_SHORT) || (a == OFS_CHAN) ||
             (a == OFS_NUM) || (a == OFS_STATUS) || (a == OFS_SENT);
  endfunction

  // byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = old;
    for (int b = 0; b < 4; b++)
      if (wstb_q[b])
        merge[b*8 +: 8] = wdat_q[b*8 +: 8];
  endfunction

  assign wr_hit = wr_fire && mapped(waddr_q);

  // address and data are taken in either order, answered when both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      waddr_q   <= '0;
      wdat_q    <= '0;
      wstb_q    <= '0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        waddr_q   <= awaddr;
        aw_held_q <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        wdat_q   <= wdata;
        wstb_q   <= wstrb;
        w_held_q <= 1'b1;
        wready   <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid    <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        awready   <= 1'b1;
        wready    <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  slbtx_cnt_type      len_q;
  slbtx_cnt_type      max_q;
  slbtx_cnt_type      min_q;
  slbtx_cnt_type      short_q;
  logic [CHAN_W-1:0]  chan_q;
  logic [15:0]        num_q;
  logic [15:0]        sent_q;
  logic [3:0]         stat_q;
  logic [31:0]        wr_m;

  always_comb begin
    wr_m = '0;
    case (waddr_q)
      OFS_LEN:   wr_m = merge(32'(len_q));
      OFS_MAX:   wr_m = merge(32'(max_q));
      OFS_MIN:   wr_m = merge(32'(min_q));
      OFS_SHORT: wr_m = merge(32'(short_q));
      OFS_CHAN:  wr_m = merge(32'(chan_q));
      OFS_NUM:   wr_m = merge(32'(num_q));
      default:   wr_m = merge(32'h0000_0000);
    endcase
  end

  // settings are loaded only when idle so a packet never sees a change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_q   <= LEN_RST;
      max_q   <= MAX_RST;
      min_q   <= MIN_RST;
      short_q <= SHORT_RST;
      chan_q  <= '0;
      num_q   <= NUM_RST;
    end else if (wr_hit && !stat_q[ST_BUSY]) begin
      case (waddr_q)
        OFS_LEN:   len_q   <= wr_m[CNT_W-1:0];
        OFS_MAX:   max_q   <= wr_m[CNT_W-1:0];
        OFS_MIN:   min_q   <= wr_m[CNT_W-1:0];
        OFS_SHORT: short_q <= wr_m[CNT_W-1:0];
        OFS_CHAN:  chan_q  <= wr_m[CHAN_W-1:0];
        OFS_NUM:   num_q   <= wr_m[15:0];
        default:   ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        case (araddr)
          OFS_LEN:    rdata <= 32'(len_q);
          OFS_MAX:    rdata <= 32'(max_q);
          OFS_MIN:    rdata <= 32'(min_q);
          OFS_SHORT:  rdata <= 32'(short_q);
          OFS_CHAN:   rdata <= 32'(chan_q);
          OFS_NUM:    rdata <= 32'(num_q);
          OFS_STATUS: rdata <= 32'(stat_q);
          OFS_SENT:   rdata <= 32'(sent_q);
          default:    rdata <= '0;
        endcase
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // scheduler
  // ----------------------------------------------------------------
  slbtx_state_type    state_q;
  slbtx_cnt_type      pos_q;
  slbtx_cnt_type      bcnt_q;
  slbtx_cnt_type      split_q;
  logic               split_v_q;
  logic [15:0]        left_q;
  logic               go;
  logic               clr;
  logic               cfg_ok;
  logic               emit;
  logic               last;
  logic               bstart;
  logic               hit;
  slbtx_cnt_type      rem;
  slbtx_cnt_type      off;
  logic [SEG_N-1:0]   ena_n;
  logic [SEG_N-1:0]   eop_n;
  logic [SEG_N*MTY_W-1:0] mty_n;
  logic [BUS_W-1:0]   data_n;

  assign go  = wr_hit && waddr_q == OFS_CTRL && wstb_q[0] &&
               wdat_q[CTRL_GO];
  assign clr = wr_hit && waddr_q == OFS_CTRL && wstb_q[0] &&
               wdat_q[CTRL_CLR];

  // legal burst settings, checked before any packet starts
  assign cfg_ok = short_q >= SHORT_MIN && short_q <= SHORT_MAX &&
                  (short_q & SHORT_GRAN) == '0 && short_q <= max_q &&
                  (max_q & BUS_GRAN) == '0 && max_q >= short_q &&
                  min_q >= BUS_BYTES && (min_q & BUS_GRAN) == '0 &&
                  min_q <= (max_q >> 1) && len_q != '0;

  // only ready cycles carry data, so no segment is valid the cycle after rdy is low
  assign emit = state_q == ST_SEND && lb.rdy && !lb.ovf;
  assign rem  = len_q - pos_q;
  assign last = rem <= BUS_BYTES;
  assign hit  = split_v_q && pos_q == split_q;
  // bursts open only on whole bus cycles, one per cycle
  assign bstart = pos_q == '0 || bcnt_q >= max_q || hit;

  // segments fill upward from zero; only the end segment may be short
  always_comb begin
    ena_n  = '0;
    eop_n  = '0;
    mty_n  = '0;
    data_n = '0;
    off    = '0;
    for (int i = 0; i < SEG_N; i++) begin
      off = pos_q + slbtx_cnt_type'(i) * SEG_BYTES;
      ena_n[i] = off < len_q;
      eop_n[i] = ena_n[i] && (off + SEG_BYTES >= len_q);
      if (eop_n[i])
        mty_n[i*MTY_W +: MTY_W] = MTY_W'(off + SEG_BYTES - len_q);
      data_n[i*SEG_W +: SEG_W] = {SEG_W/32{32'(off)}};
    end
  end

  // packet sequencing; a new start only after the end cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      pos_q   <= '0;
      left_q  <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          pos_q <= '0;
          if (go && cfg_ok) begin
            left_q  <= num_q;
            state_q <= (num_q == '0) ? ST_IDLE : ST_SEND;
          end
        end
        ST_SEND: begin
          if (lb.ovf)
            state_q <= ST_HALT;
          else if (emit) begin
            pos_q <= last ? '0 : pos_q + BUS_BYTES;
            if (last) begin
              left_q <= left_q - 16'h0001;
              if (left_q == 16'h0001)
                state_q <= ST_IDLE;
            end
          end
        end
        ST_HALT: begin
          if (clr)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // bursts run at max size; a final stretch longer than max but short of max plus min splits into two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bcnt_q    <= '0;
      split_q   <= '0;
      split_v_q <= 1'b0;
    end else if (emit) begin
      bcnt_q <= bstart ? BUS_BYTES : bcnt_q + BUS_BYTES;
      if (last)
        split_v_q <= 1'b0;
      else if (bstart && rem > max_q && rem < max_q + min_q) begin
        split_q   <= pos_q + ((rem - min_q) & ~BUS_GRAN);
        split_v_q <= 1'b1;
      end else if (hit)
        split_v_q <= 1'b0;
    end
  end

  // bus outputs registered; idle cycles drive no valid segment
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lb.ena         <= '0;
      lb.sop         <= '0;
      lb.eop         <= '0;
      lb.force_burst <= '0;
      lb.mty         <= '0;
      lb.data        <= '0;
      lb.chan        <= '0;
    end else begin
      lb.ena         <= emit ? ena_n : '0;
      lb.sop         <= emit ? SEG_N'(pos_q == '0) : '0;
      lb.eop         <= emit ? eop_n : '0;
      lb.force_burst <= (emit && hit) ? SEG_N'(1) : '0;
      lb.mty         <= emit ? mty_n : '0;
      lb.data        <= emit ? data_n : '0;
      lb.chan        <= {SEG_N{chan_q}};
    end
  end

  // burst settings shared with the framer, stable during sending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lb.burst_short <= SHORT_RST;
      lb.burst_max   <= MAX_RST;
    end else begin
      lb.burst_short <= short_q;
      lb.burst_max   <= max_q;
    end
  end

  // status: busy follows the state, the other flags are sticky and a new event wins over a clear in that cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
      sent_q <= '0;
    end else begin
      stat_q[ST_BUSY] <= (state_q != ST_IDLE);
      stat_q[ST_OVF]  <= lb.ovf || (stat_q[ST_OVF] && !clr);
      stat_q[ST_BERR] <= lb.burst_err || (stat_q[ST_BERR] && !clr);
      stat_q[ST_CFG]  <= (go && !cfg_ok) || (stat_q[ST_CFG] && !clr);
      if (go && cfg_ok)
        sent_q <= '0;
      else if (emit && last)
        sent_q <= sent_q + 16'h0001;
    end
  end

endmodule

// *** slbtx_props.sv ***
// concurrent checks on the segmented transmit bus
`timescale 1ns/10ps
module slbtx_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [3:0] ena,
  input wire logic [3:0] sop,
  input wire logic [3:0] eop,
  input wire logic [3:0] force_burst,
  input wire logic       rdy,
  input wire logic       ovf,
  input wire logic       burst_err
);
  logic open_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // open packet tracking
  // ----
  // a start and an end in one cycle leave nothing open
  always_ff @(posedge aclk) begin
    if (!aresetn) open_q <= 1'b0;
    else open_q <= (open_q | (|(sop & ena))) & ~(|(eop & ena));
  end
  // ----
  // bus rules
  // ----
  one_start_a: assert property ($onehot0(sop))
    else $error("two starts in one cycle");
  start_closed_a: assert property (|sop |-> !open_q)
    else $error("start while packet open");
  no_gap_a: assert property (ena[0] && !(|eop) |-> ena == 4'hf)
    else $error("idle segment inside packet");
  seg_contig_a: assert property (ena[0] |-> ena inside {1, 3, 7, 15})
    else $error("active segments not contiguous");
  bp_idle_a: assert property (!rdy |=> ena == 4'h0)
    else $error("data while back-pressured");
  rdy_limit_a: assert property (!rdy [*8] |=> ena == 4'h0)
    else $error("data after long ready low");
  ovf_halt_a: assert property (ovf |=> ovf && ena == 4'h0)
    else $error("transfer after overflow");
  one_word_a: assert property (!burst_err)
    else $error("two burst words in one cycle");
  idle_cause_a: assert property (open_q && ena == 0 |-> !$past(rdy))
    else $error("idle cycle inside packet");
  mark_active_a: assert property ((force_burst & ~ena) == 4'h0)
    else $error("forced burst word on idle segment");
  cover property (|force_burst);
  cover property (!rdy ##1 rdy);
  cover property (sop[0] && eop[0]);
endmodule

// *** slbtx_test.sv ***
// bench joining scheduler and framer, with a packet length model
`timescale 1ns/10ps
module slbtx_test;
  import slbtx_pkg::*;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid;
  logic        arready, rvalid;
  logic [5:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rv[6] = '{32'h0000_0108, 32'h0000_0100, 32'h0000_0040,
                         32'h0000_0040, 32'h0000_0000, 32'h0000_0001};
  int          n_mismatch = 0, check_count = 0, bytes, beat, fb, fexp;
  int          q[$];
  int          bb = 0, cw = 0, iw = 0;
  localparam int DEPTH = 64;
  logic [FILL_W-1:0] ctl_w, idl_w, fill_l;
  logic [SEG_N-1:0]  bcw_s;
  slbtx_if lb ();
  slbtx_dev #(.FILL_DEPTH(DEPTH), .RDY_LEVEL(32)) slbtx_dev_inst (.aclk,
    .aresetn, .lb, .bcw_seg(bcw_s), .ctl_words(ctl_w),
    .idle_words(idl_w), .fill_level(fill_l));
  slbtx_sched slbtx_sched_inst (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .lb);
  slbtx_props slbtx_props_inst (.aclk, .aresetn, .ena(lb.ena),
    .sop(lb.sop), .eop(lb.eop), .force_burst(lb.force_burst),
    .rdy(lb.rdy), .ovf(lb.ovf), .burst_err(lb.burst_err));
  // free-running clock, 4 ns period
  always #2 aclk = ~aclk;
  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // model: bytes and beat of each packet, split word position
  always @(posedge aclk) begin
    if (aresetn && lb.ena[0] === 1'b1) begin
      beat = lb.sop[0] ? 0 : beat + 1;
      if (lb.sop[0]) bytes = 0;
      for (int j = 0; j < SEG_N; j++) begin
        if (lb.ena[j]) bytes += 16 - (lb.eop[j] ? lb.mty[j*4+:4] : 0);
        if (lb.ena[j] && lb.eop[j])
          chk(q.size() > 0 && bytes == q.pop_front(), "length");
      end
      if (lb.force_burst[0]) chk(beat == fexp, "split beat");
      fb += int'(lb.force_burst[0]);
    end
  end
  // model of burst and idle words the framer adds; seen one cycle later
  // the backlog must stay within the lanes, or overflow would follow
  always @(posedge aclk) begin
    if (aresetn) begin
      chk(ctl_w === FILL_W'(cw) && bcw_s === SEG_N'(cw), "burst word");
      chk(idl_w === FILL_W'(iw) && fill_l <= FILL_W'(DEPTH), "idles");
    end
    cw = 0;
    iw = 0;
    if (aresetn && lb.ena[0] === 1'b1) begin
      if (lb.sop[0] || lb.force_burst[0] || bb >= int'(MAX_RST)) begin
        cw = 1;
        bb = 0;
      end
      for (int j = 0; j < SEG_N; j++) begin
        if (lb.ena[j]) bb += 16 - (lb.eop[j] ? lb.mty[j*4+:4] : 0);
        if (lb.ena[j] && lb.eop[j] && bb < int'(SHORT_RST))
          iw = (int'(SHORT_RST) - bb + 7) / 8;
      end
    end
  end
  // two packets back to back; split only when the tail is under 64
  task automatic run(input int n);
    fexp = (n > 256 && n % 256 > 0 && n % 256 < 64) ? 4 * (n / 256) - 1 : -1;
    fb = 0;
    repeat (2) q.push_back(n);
    wr(OFS_LEN, 32'(n));
    wr(OFS_NUM, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0001);
    while (q.size() > 0) @(posedge aclk);
    do rd(OFS_STATUS); while (d[ST_BUSY] !== 1'b0);
    chk(fb == 2 * int'(fexp >= 0), "split count");
    chk(d[3:1] === 3'b000, "status flags");
    $display("test length %0d done", n);
  endtask
  initial begin
    void'($urandom(99414));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rv[i]) begin
      rd(6'(4 + 4 * i));
      chk(d === rv[i] && r === RESP_OKAY, "reset value");
    end
    rd(6'h3c);
    chk(r === RESP_SLVERR && d === 32'h0, "unmapped read");
    wr(OFS_SHORT, 32'h0000_0030);
    wr(OFS_CTRL, 32'h0000_0001);
    rd(OFS_STATUS);
    chk(d[ST_CFG] === 1'b1 && q.size() == 0, "short refused");
    wr(OFS_SHORT, 32'h0000_0040);
    wr(OFS_CTRL, 32'h0000_0002);
    $display("test config done");
    run(264);
    run(520);
    run(64);
    run(40);
    run(1 + $urandom % 700);
    conclude();
  end
  // watchdog well past the expected run time
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule
